// ===== shared/skc_pkg.sv
// Purpose: Constants and types for the shutdown and key configuration block
// Assumes: 100 MHz system clock; all timers count in 1 ms ticks
// Notes:   Register offsets are the 9-bit register port addresses
package skc_pkg;
  // Register port
  localparam int          ADDR_W    = 9;
  localparam logic [8:0]  OFS_CFG_I = 9'h10E;
  localparam logic [8:0]  OFS_CFG_J = 9'h10F;
  localparam logic [8:0]  OFS_CFG_K = 9'h110;
  localparam logic [7:0]  RST_CFG_I = 8'h00;
  localparam logic [7:0]  RST_CFG_J = 8'h00;
  localparam logic [7:0]  RST_CFG_K = 8'h00;
  // Field positions, shutdown and key mode register
  localparam int I_CURRENT_LIMIT_SHUTDOWN_ENABLE    = 7;
  localparam int I_INT_FAST  = 6;
  localparam int I_HOST_FAST = 5;
  localparam int I_KEY_POR   = 4;
  localparam int I_DUAL_SD   = 3;
  localparam int I_KEY_SD    = 2;
  localparam int I_KEY_MODE  = 0;
  // Field positions, interface reset and key timing register
  localparam int J_IF_RST    = 7;
  localparam int J_TW_TO     = 6;
  localparam int J_RST_DUR   = 4;
  localparam int J_SHUT_DLY  = 2;
  localparam int J_KEY_DLY   = 0;
  // Power button modes
  localparam logic [1:0] KEY_PORT   = 2'h0;
  localparam logic [1:0] KEY_SWLOCK = 2'h1;
  localparam logic [1:0] KEY_MULTI  = 2'h2;
  localparam logic [1:0] KEY_DEDIC  = 2'h3;
  // Timing: clock rate and times in ms
  localparam int          CLK_KHZ  = 100000;
  localparam logic [16:0] TICK_CYC = 17'(CLK_KHZ);
  localparam int          TMR_W    = 14;
  localparam logic [13:0] ILIM_MS  = 14'd200;
  localparam logic [13:0] TW_MS    = 14'd19;
  // Timer index assignment
  localparam int NT = 5;
  localparam int T_ILIM = 0;
  localparam int T_TW   = 1;
  localparam int T_RST  = 2;
  localparam int T_KEY  = 3;
  localparam int T_DUAL = 4;
  // Controller states
  typedef enum logic {ST_RESET, ST_RUN} skc_state_t;
  // Minimum reset duration in ms
  function automatic logic [13:0] rst_ms(input logic [1:0] sel);
    case (sel)
      2'h0: rst_ms = 14'd20;
      2'h1: rst_ms = 14'd100;
      2'h2: rst_ms = 14'd500;
      default: rst_ms = 14'd1000;
    endcase
  endfunction
  // Lock delay in ms
  function automatic logic [13:0] key_ms(input logic [1:0] sel);
    case (sel)
      2'h0: key_ms = 14'd1000;
      2'h1: key_ms = 14'd1500;
      2'h2: key_ms = 14'd2000;
      default: key_ms = 14'd7000;
    endcase
  endfunction
  // Extra shutdown time in ms
  function automatic logic [13:0] shut_ms(input logic [1:0] sel);
    case (sel)
      2'h0: shut_ms = 14'd0;
      2'h1: shut_ms = 14'd4000;
      2'h2: shut_ms = 14'd5000;
      default: shut_ms = 14'd6000;
    endcase
  endfunction
endpackage

// ===== shared/skc_tmr_if.sv
// Purpose: Carrier between the controller and one millisecond timer
// Assumes: tick is a one-cycle pulse every millisecond
// Notes:   expired is a level, fire a pulse on the first expired cycle
`timescale 1ns/1ps
interface skc_tmr_if;
  logic                      tick;
  logic                      run;
  logic [skc_pkg::TMR_W-1:0] limit;
  logic [skc_pkg::TMR_W-1:0] count;
  logic                      expired;
  logic                      fire;
  modport tmr (input tick, run, limit, output count, expired, fire);
  modport ctl (output tick, run, limit, input count, expired, fire);
endinterface

// ===== verilog/skc_timer.sv
// Purpose: Millisecond hold timer, expires once count passes the limit
// Assumes: run and limit come from logic on the same clock
// Notes:   Count clears whenever run drops; count saturates
`timescale 1ns/1ps
module skc_timer (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Timer carrier
  skc_tmr_if.tmr   t
);
  import skc_pkg::*;

  typedef struct packed {
    logic [TMR_W-1:0] count;
    logic             expired;
    logic             fire;
  } skc_tmr_st_t;

  skc_tmr_st_t s;
  skc_tmr_st_t next_s;

  // Count ticks while running, flag strictly past the limit
  always_comb begin
    next_s = s;
    if (!t.run) begin
      next_s.count = '0;
    end else if (t.tick && (s.count != '1)) begin
      next_s.count = s.count + 1'b1;
    end
    next_s.expired = t.run && (next_s.count > t.limit);
    next_s.fire    = next_s.expired && !s.expired;
  end

  // State register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign t.count   = s.count;
  assign t.expired = s.expired;
  assign t.fire    = s.fire;
endmodule

// ===== verilog/skc_top.sv
// Purpose: Shutdown, power key and pull configuration of a power controller
// Assumes: Pins and regulator limit flags are asynchronous and synchronised
// Notes:   Timers run on a 1 ms tick; TICK_CYCLES shortens it for simulation
// Function
// R1: With limit shutdown enabled, a regulator in limit over 200 ms turns off the four regulators.
// R2: An internal fault starts the normal sequence, or the fast one if its fast bit is set.
// R3: A host shutdown by bit or pin starts the normal sequence, or the fast one if its fast bit is set.
// R4: With the user mode bit set, a user shutdown is an instant reset that turns off every regulator.
// R5: After such an instant reset, power-up waits until the reset duration has run out.
// R6: Holding both general inputs 14 and 15 shuts down only when the dual-input enable is set.
// R7: A long press of the button shuts down only when the button shutdown enable is set.
// R8: The two-bit mode field picks port, software lock, multi-function or dedicated power key.
// R9: With interface reset enabled, an asserted shutdown pin resets all control interfaces.
// R10: With the timeout enabled, a two-wire clock idle over 19 ms resets that interface.
// R11: The controller stays in reset at least 20, 100, 500 or 1000 ms as the field selects.
// R12: The long-press shutdown threshold is the lock delay plus 0, 4, 5 or 6 s.
// R13: The lock indication rises after the button is held 1, 1.5, 2 or 7 s.
// R14: A clear pull bit disables the pin's pull-down as input and pull-up as open-drain output.
// R15: A set pull bit enables the pull-down as input or pull-up as output; bit n is pin n.
`timescale 1ns/1ps
module skc_top #(
  parameter logic [16:0] TICK_CYCLES = skc_pkg::TICK_CYC
) (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       arst_n,
  // Register port
  input  wire logic [skc_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic                       reg_wr,
  input  wire logic [7:0]                 reg_wdata,
  output logic      [7:0]                 reg_rdata,
  // Pins
  input  wire logic                       power_button_pin_n,
  input  wire logic                       shutdown_request_pin_n,
  input  wire logic                       general_input_fourteen,
  input  wire logic                       general_input_fifteen,
  input  wire logic                       two_wire_scl,
  // Regulator limit flags
  input  wire logic [3:0]                 ldo_in_limit,
  // Same-clock system inputs
  input  wire logic                       internal_fault,
  input  wire logic                       host_shutdown_bit,
  input  wire logic                       sw_powerdown,
  input  wire logic [7:0]                 pin_is_output,
  // Sequencer and regulator controls
  output logic                            ldo_off,
  output logic                            sd_start,
  output logic                            sd_fast,
  output logic                            instant_por,
  output logic                            powerup_ok,
  // Key outputs
  output logic                            button_lock_indication,
  output logic                            partial_powerdown,
  // Interface resets
  output logic                            if_reset,
  output logic                            two_wire_reset,
  // Pull controls
  output logic      [7:0]                 pull_down_en,
  output logic      [7:0]                 pull_up_en
);
  import skc_pkg::*;

  // Assertions sample on the system clock and rest while in reset
  default clocking skc_cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  typedef struct packed {
    logic [7:0]  cfg_i;
    logic [7:0]  cfg_j;
    logic [7:0]  cfg_k;
    logic [7:0]  rdata;
    logic [4:0]  p1;
    logic [4:0]  p2;
    logic [3:0]  l1;
    logic [3:0]  l2;
    logic        scl_d;
    logic        shdn_d;
    logic        btn_d;
    logic [16:0] pre;
    logic        tick;
    skc_state_t  state;
    logic        lock;
    logic        ldo_off;
    logic        sd_start;
    logic        sd_fast;
    logic        por;
    logic        part_pd;
    logic        if_rst;
    logic        tw_rst;
    logic [7:0]  pd_en;
    logic [7:0]  pu_en;
  } skc_top_st_t;

  skc_top_st_t s;
  skc_top_st_t next_s;

  logic [TMR_W-1:0] tmr_lim [NT];
  logic [TMR_W-1:0] tmr_cnt [NT];
  logic [NT-1:0]    tmr_run;
  logic [NT-1:0]    tmr_exp;
  logic [NT-1:0]    tmr_fire;

  // Synchronised pin levels, active high
  logic btn;
  logic shdn;
  logic g14;
  logic g15;
  logic scl;
  assign btn  = ~s.p2[0];
  assign shdn = ~s.p2[1];
  assign g14  = s.p2[2];
  assign g15  = s.p2[3];
  assign scl  = s.p2[4];

  // Decoded configuration
  logic [1:0]       mode;
  logic [TMR_W-1:0] lock_ms;
  logic [TMR_W-1:0] long_ms;
  assign mode    = s.cfg_i[I_KEY_MODE +: 2];
  assign lock_ms = key_ms(s.cfg_j[J_KEY_DLY +: 2]);
  assign long_ms = lock_ms + shut_ms(s.cfg_j[J_SHUT_DLY +: 2]); // [R12]

  // Timer requests
  assign tmr_run[T_ILIM] = s.cfg_i[I_CURRENT_LIMIT_SHUTDOWN_ENABLE] && (|s.l2);        // [R1]
  assign tmr_lim[T_ILIM] = ILIM_MS;
  assign tmr_run[T_TW]   = s.cfg_j[J_TW_TO] && (scl == s.scl_d); // [R10]
  assign tmr_lim[T_TW]   = TW_MS;
  assign tmr_run[T_RST]  = (s.state == ST_RESET);                // [R11]
  assign tmr_lim[T_RST]  = rst_ms(s.cfg_j[J_RST_DUR +: 2]);
  assign tmr_run[T_KEY]  = btn && (mode != KEY_PORT);            // [R8]
  assign tmr_lim[T_KEY]  = long_ms;
  assign tmr_run[T_DUAL] = s.cfg_i[I_DUAL_SD] && g14 && g15;     // [R6]
  assign tmr_lim[T_DUAL] = long_ms;

  // One timer per hold condition
  for (genvar i = 0; i < NT; i++) begin : g_tmr
    skc_tmr_if tif ();
    assign tif.tick    = s.tick;
    assign tif.run     = tmr_run[i];
    assign tif.limit   = tmr_lim[i];
    assign tmr_cnt[i]  = tif.count;
    assign tmr_exp[i]  = tif.expired;
    assign tmr_fire[i] = tif.fire;
    skc_timer u_tmr (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .t       (tif.tmr)
    );
  end

  // Shutdown causes
  logic key_auto;
  logic key_sd;
  logic user_sd;
  logic host_sd;
  logic lock_ok;
  assign key_auto = (mode == KEY_MULTI) || (mode == KEY_DEDIC);
  assign key_sd   = tmr_fire[T_KEY] && s.cfg_i[I_KEY_SD] && key_auto; // [R7]
  assign user_sd  = key_sd || tmr_fire[T_DUAL];                       // [R6]
  assign host_sd  = host_shutdown_bit || (shdn && !s.shdn_d);         // [R3]
  assign lock_ok  = key_auto || ((mode == KEY_SWLOCK) && sw_powerdown);

  // Next-state logic
  always_comb begin
    next_s          = s;
    // Register writes and registered read data
    if (reg_wr) begin
      case (reg_addr)
        OFS_CFG_I: next_s.cfg_i = reg_wdata;
        OFS_CFG_J: next_s.cfg_j = reg_wdata;
        OFS_CFG_K: next_s.cfg_k = reg_wdata;
        default:   next_s.cfg_k = s.cfg_k;
      endcase
    end
    case (reg_addr)
      OFS_CFG_I: next_s.rdata = s.cfg_i;
      OFS_CFG_J: next_s.rdata = s.cfg_j;
      OFS_CFG_K: next_s.rdata = s.cfg_k;
      default:   next_s.rdata = 8'h00;
    endcase
    // Two-flop synchronisers and edge history
    next_s.p1 = {two_wire_scl, general_input_fifteen,
                 general_input_fourteen, shutdown_request_pin_n,
                 power_button_pin_n};
    next_s.p2     = s.p1;
    next_s.l1     = ldo_in_limit;
    next_s.l2     = s.l1;
    next_s.scl_d  = scl;
    next_s.shdn_d = shdn;
    next_s.btn_d  = btn;
    // Millisecond tick
    next_s.tick = (s.pre == TICK_CYCLES - 17'h00001);
    next_s.pre  = next_s.tick ? 17'h00000 : s.pre + 17'h00001;
    // Lock indication while held past the lock delay
    next_s.lock = tmr_run[T_KEY] && (tmr_cnt[T_KEY] >= lock_ms) &&
                  lock_ok; // [R13]
    // Dedicated key released after lock but before shutdown time
    next_s.part_pd = (mode == KEY_DEDIC) && s.btn_d && !btn &&
                     s.lock && !tmr_exp[T_KEY]; // [R8]
    // Pulses default low
    next_s.sd_start = 1'b0;
    next_s.por      = 1'b0;
    case (s.state)
      ST_RESET: begin
        if (tmr_exp[T_RST]) begin
          next_s.state = ST_RUN; // [R5] [R11]
        end
      end
      ST_RUN: begin
        if (user_sd && s.cfg_i[I_KEY_POR]) begin
          next_s.por   = 1'b1; // [R4]
          next_s.state = ST_RESET;
        end else if (internal_fault) begin
          next_s.sd_start = 1'b1;
          next_s.sd_fast  = s.cfg_i[I_INT_FAST]; // [R2]
        end else if (host_sd) begin
          next_s.sd_start = 1'b1;
          next_s.sd_fast  = s.cfg_i[I_HOST_FAST]; // [R3]
        end else if (user_sd) begin
          next_s.sd_start = 1'b1;
          next_s.sd_fast  = 1'b0; // [R4]
        end
      end
      default: begin
        next_s.state = ST_RESET;
      end
    endcase
    // Limit trip is sticky; a new trip wins over any clear
    next_s.ldo_off = tmr_fire[T_ILIM] ||
                     (s.ldo_off && s.cfg_i[I_CURRENT_LIMIT_SHUTDOWN_ENABLE] && !next_s.por); // [R1]
    // Interface resets
    next_s.if_rst = s.cfg_j[J_IF_RST] && shdn;  // [R9]
    next_s.tw_rst = tmr_fire[T_TW];             // [R10]
    // Pull enables per pin direction
    next_s.pd_en = s.cfg_k & ~pin_is_output;    // [R14] [R15]
    next_s.pu_en = s.cfg_k & pin_is_output;     // [R14] [R15]
  end

  // State register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s       <= '0;
      s.cfg_i <= RST_CFG_I;
      s.cfg_j <= RST_CFG_J;
      s.cfg_k <= RST_CFG_K;
      s.p1    <= 5'h13;
      s.p2    <= 5'h13;
      s.scl_d <= 1'b1; // Idle clock line is high, no false edge
      s.state <= ST_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Outputs
  assign reg_rdata              = s.rdata;
  assign ldo_off                = s.ldo_off;
  assign sd_start               = s.sd_start;
  assign sd_fast                = s.sd_fast;
  assign instant_por            = s.por;
  assign powerup_ok             = (s.state == ST_RUN);
  assign button_lock_indication = s.lock;
  assign partial_powerdown      = s.part_pd;
  assign if_reset               = s.if_rst;
  assign two_wire_reset         = s.tw_rst;
  assign pull_down_en           = s.pd_en;
  assign pull_up_en             = s.pu_en;

  // Limit trip follows the timer and needs the enable
  ldo_trip_a: assert property ( // [R1]
    tmr_fire[T_ILIM] |=> ldo_off ##0 $past(s.cfg_i[I_CURRENT_LIMIT_SHUTDOWN_ENABLE], 2))
    else $error("limit trip without shutdown");

  // Internal fault picks its own fast bit
  int_fast_a: assert property ( // [R2]
    (s.state == ST_RUN && internal_fault &&
     !(user_sd && s.cfg_i[I_KEY_POR]))
    |=> sd_start && (sd_fast == $past(s.cfg_i[I_INT_FAST])))
    else $error("internal fault sequence wrong");

  // Host request picks its own fast bit
  host_fast_a: assert property ( // [R3]
    (s.state == ST_RUN && host_sd && !internal_fault &&
     !(user_sd && s.cfg_i[I_KEY_POR]))
    |=> sd_start && (sd_fast == $past(s.cfg_i[I_HOST_FAST])))
    else $error("host sequence wrong");

  // Instant reset drops readiness and clears the limit trip
  por_reset_a: assert property ( // [R4]
    instant_por |-> !powerup_ok && !ldo_off && $past(s.cfg_i[I_KEY_POR]))
    else $error("instant reset not taken");

  // Readiness only after the reset duration
  reset_wait_a: assert property ( // [R5] [R11]
    $rose(powerup_ok) |-> $past(tmr_exp[T_RST]) &&
    ($past(tmr_cnt[T_RST]) > $past(tmr_lim[T_RST])))
    else $error("left reset too early");

  // Dual input hold is ignored while disabled
  dual_off_a: assert property ( // [R6]
    !$past(s.cfg_i[I_DUAL_SD]) |-> !tmr_fire[T_DUAL])
    else $error("dual input hold while disabled");

  // Interface reset mirrors enabled shutdown pin
  if_reset_a: assert property ( // [R9]
    if_reset == $past(s.cfg_j[J_IF_RST] && shdn))
    else $error("interface reset mismatch");

  // Two-wire reset needs the timeout enable
  tw_reset_a: assert property ( // [R10]
    two_wire_reset |-> $past(s.cfg_j[J_TW_TO], 2))
    else $error("two-wire reset while disabled");

  // Long press fires only past lock plus extra time
  long_press_a: assert property ( // [R12]
    tmr_fire[T_KEY] |-> tmr_cnt[T_KEY] > $past(long_ms))
    else $error("long press threshold wrong");

  // Lock only after the lock delay
  key_lock_a: assert property ( // [R13]
    $rose(button_lock_indication) |->
    $past(tmr_cnt[T_KEY]) >= $past(lock_ms))
    else $error("lock raised early");

  // Pull enables follow bit and direction
  pull_map_a: assert property ( // [R14] [R15]
    (pull_down_en | pull_up_en) == $past(s.cfg_k) &&
    (pull_up_en & ~$past(pin_is_output)) == 8'h00)
    else $error("pull enable mismatch");

  // Partial powerdown only from a locked dedicated key
  part_pd_a: assert property ( // [R8]
    partial_powerdown |-> ($past(mode) == KEY_DEDIC) && $past(s.lock))
    else $error("partial powerdown without locked key");

  // Port mode never locks the button
  port_lock_a: assert property ( // [R8] [R13]
    button_lock_indication |-> ($past(mode) != KEY_PORT))
    else $error("lock in port mode");

  // Instant reset only follows a user shutdown while running
  por_cause_a: assert property ( // [R4]
    instant_por |-> $past(user_sd) && ($past(s.state) == ST_RUN))
    else $error("instant reset without user shutdown");
endmodule

// ===== bench/skc_host_model.sv
// Purpose: Host and user side of the shutdown and key block
// Assumes: Pins change only at the falling clock edge
// Notes:   Two-wire clock stands high by its pull-up while stopped
`timescale 1ns/1ps
module skc_host_model (
  // Clock
  input  wire logic sys_clk,
  // Pins towards the device
  output logic      power_button_pin_n,
  output logic      shutdown_request_pin_n,
  output logic      general_input_fourteen,
  output logic      general_input_fifteen,
  output logic      two_wire_scl
);
  logic       scl_run;
  logic [1:0] scl_div;
  // Idle levels: button and pin released, inputs low, clock high
  initial begin
    scl_run = 1'b0;
    scl_div = 2'h0;
    two_wire_scl = 1'b1;
    set_now(1'b0, 1'b0, 1'b0, 1'b0);
  end
  // Drive pins, active low where the name says so
  task automatic set_now(input logic b, input logic g4, input logic g5,
                         input logic sd);
    power_button_pin_n = ~b;
    general_input_fourteen = g4;
    general_input_fifteen = g5;
    shutdown_request_pin_n = ~sd;
  endtask
  // Change pins just after a falling edge
  task automatic set_pins(input logic b, input logic g4, input logic g5,
                          input logic sd);
    @(negedge sys_clk);
    set_now(b, g4, g5, sd);
  endtask
  // Start or stop the two-wire clock
  task automatic scl_enable(input logic on);
    @(negedge sys_clk);
    scl_run = on;
  endtask
  // Toggle every fourth cycle while running
  always @(negedge sys_clk) begin
    scl_div <= scl_div + 2'h1;
    if (!scl_run) begin
      two_wire_scl <= 1'b1;
    end else if (scl_div == 2'h3) begin
      two_wire_scl <= ~two_wire_scl;
    end
  end
endmodule

// ===== bench/tb.sv
// Purpose: Self-checking bench of the shutdown and key configuration block
// Assumes: One millisecond is shortened to 10 clock cycles
// Notes:   Timing windows allow for tick phase and pin synchronisers
`timescale 1ns/1ps
module tb;
  import skc_pkg::*;
  // Design inputs
  logic                sys_clk, arst_n, reg_wr;
  logic [ADDR_W-1:0]   reg_addr;
  logic [7:0]          reg_wdata, pin_is_output;
  logic [3:0]          ldo_in_limit;
  logic                internal_fault, host_shutdown_bit, sw_powerdown;
  // Pins and design outputs
  logic                power_button_pin_n, shutdown_request_pin_n;
  logic                general_input_fourteen, general_input_fifteen;
  logic                two_wire_scl;
  logic [7:0]          reg_rdata, pull_down_en, pull_up_en;
  logic                ldo_off, sd_start, sd_fast, instant_por, powerup_ok;
  logic                button_lock_indication, partial_powerdown;
  logic                if_reset, two_wire_reset;
  int                  fails, n_tests, seed;
  logic [7:0]          d;
  logic [ADDR_W-1:0]   ofs [3];

  skc_top #(.TICK_CYCLES(17'd10)) u_skc_top (.*);
  skc_host_model u_skc_host_model (.sys_clk, .power_button_pin_n,
    .shutdown_request_pin_n, .general_input_fourteen,
    .general_input_fifteen, .two_wire_scl);

  // Clock of 10 ns
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Expected pull enables for pin direction
  function automatic logic [7:0] exp_pull(input logic [7:0] en,
                                          input logic [7:0] o,
                                          input logic up);
    return up ? (en & o) : (en & ~o);
  endfunction
  // Output picked by index
  function automatic logic sig(input int s);
    case (s)
      0: return sd_start;
      1: return instant_por;
      2: return powerup_ok;
      3: return button_lock_indication;
      4: return ldo_off;
      5: return if_reset;
      7: return partial_powerdown;
      default: return two_wire_reset;
    endcase
  endfunction
  // Closing report
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Cycles until an output rises must fall in lo..hi
  task automatic wait_rise(input int s, input int lo, input int hi);
    int n;
    n = 0;
    while (n < hi && sig(s) !== 1'b1) begin
      @(negedge sys_clk);
      n++;
    end
    n_tests++;
    if (sig(s) !== 1'b1 || n < lo) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, n, lo);
      if (sig(s) !== 1'b1) end_of_test();
    end
  endtask
  // Output must stay low for n cycles
  task automatic wait_none(input int s, input int n);
    int hit;
    hit = 0;
    repeat (n) begin
      @(negedge sys_clk);
      if (sig(s) !== 1'b0) hit++;
    end
    chk(8'(hit != 0), 8'h00);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    @(negedge sys_clk);
    reg_addr = a;
    @(negedge sys_clk);
    chk(reg_rdata, e);
  endtask
  // Configure, drive button and dual inputs, time the response
  task automatic key_run(input logic [7:0] cfg, input logic [2:0] p,
                         input int s, input int lo, input int hi);
    wr(OFS_CFG_I, cfg);
    u_skc_host_model.set_pins(p[2], p[1], p[0], 1'b0);
    wait_rise(s, lo, hi);
  endtask

  // Main sequence
  initial begin
    arst_n = 1'b0;
    reg_wr = 1'b0;
    reg_addr = '0;
    reg_wdata = 8'h00;
    pin_is_output = 8'h00;
    ldo_in_limit = 4'h0;
    internal_fault = 1'b0;
    host_shutdown_bit = 1'b0;
    sw_powerdown = 1'b0;
    fails = 0;
    n_tests = 0;
    seed = 42044;
    ofs = '{OFS_CFG_I, OFS_CFG_J, OFS_CFG_K};
    repeat (10) @(negedge sys_clk);
    arst_n = 1'b1;
    wait_rise(2, 200, 240);
    // Reset values, read back, unmapped place
    for (int i = 0; i < 3; i++) begin
      rd(ofs[i], 8'h00);
      d = 8'($random(seed));
      wr(ofs[i], d);
      rd(ofs[i], d);
      wr(ofs[i], 8'h00);
    end
    wr(9'h111, 8'hFF);
    rd(9'h111, 8'h00);
    // Pull enables against pin direction
    repeat (8) begin
      d = 8'($random(seed));
      pin_is_output = 8'($random(seed));
      wr(OFS_CFG_K, d);
      repeat (2) @(negedge sys_clk);
      chk(pull_down_en, exp_pull(d, pin_is_output, 1'b0));
      chk(pull_up_en, exp_pull(d, pin_is_output, 1'b1));
    end
    // Regulator current limit
    wr(OFS_CFG_I, 8'h80);
    ldo_in_limit = 4'h1 << ($unsigned($random(seed)) % 4);
    wait_rise(4, 2001, 2045);
    ldo_in_limit = 4'h0;
    wr(OFS_CFG_I, 8'h00);
    repeat (2) @(negedge sys_clk);
    chk(8'(ldo_off), 8'h00);
    ldo_in_limit = 4'hF;
    wait_none(4, 2100);
    ldo_in_limit = 4'h0;
    // Fault, host bit and host pin with both fast settings
    for (int f = 0; f < 2; f++) begin
      wr(OFS_CFG_I, 8'(f << I_INT_FAST) | 8'((1 - f) << I_HOST_FAST));
      @(negedge sys_clk);
      internal_fault = 1'b1;
      @(negedge sys_clk);
      internal_fault = 1'b0;
      wait_rise(0, 0, 4);
      chk(8'(sd_fast), 8'(f));
      @(negedge sys_clk);
      host_shutdown_bit = 1'b1;
      @(negedge sys_clk);
      host_shutdown_bit = 1'b0;
      wait_rise(0, 0, 4);
      chk(8'(sd_fast), 8'(1 - f));
      u_skc_host_model.set_pins(1'b0, 1'b0, 1'b0, 1'b1);
      wait_rise(0, 1, 6);
      chk(8'(sd_fast), 8'(1 - f));
      u_skc_host_model.set_pins(1'b0, 1'b0, 1'b0, 1'b0);
    end
    // Interface reset on the shutdown pin, enabled then not
    wr(OFS_CFG_J, 8'h80);
    u_skc_host_model.set_pins(1'b0, 1'b0, 1'b0, 1'b1);
    wait_rise(5, 1, 6);
    u_skc_host_model.set_pins(1'b0, 1'b0, 1'b0, 1'b0);
    wr(OFS_CFG_J, 8'h00);
    u_skc_host_model.set_pins(1'b0, 1'b0, 1'b0, 1'b1);
    wait_none(5, 20);
    u_skc_host_model.set_pins(1'b0, 1'b0, 1'b0, 1'b0);
    // Two-wire clock stalls
    wr(OFS_CFG_J, 8'h40);
    u_skc_host_model.scl_enable(1'b1);
    wait_none(6, 300);
    u_skc_host_model.scl_enable(1'b0);
    wait_rise(6, 185, 230);
    wr(OFS_CFG_J, 8'h00);
    // Long presses over the key modes
    key_run(8'h06, 3'b100, 3, 9990, 10030);
    wait_rise(0, 1, 45);
    chk(8'(sd_fast), 8'h00);
    u_skc_host_model.set_pins(1'b0, 1'b0, 1'b0, 1'b0);
    wr(OFS_CFG_I, 8'h04);
    u_skc_host_model.set_pins(1'b1, 1'b0, 1'b0, 1'b0);
    wait_none(0, 10100);
    wait_none(3, 100);
    u_skc_host_model.set_pins(1'b0, 1'b0, 1'b0, 1'b0);
    // Software lock mode: lock with powerdown, never a key shutdown
    sw_powerdown = 1'b1;
    key_run(8'h05, 3'b100, 3, 9990, 10030);
    wait_none(0, 100);
    sw_powerdown = 1'b0;
    u_skc_host_model.set_pins(1'b0, 1'b0, 1'b0, 1'b0);
    // Dedicated key released after lock, before the shutdown time; dual inputs off and on; instant reset
    key_run(8'h03, 3'b100, 3, 9990, 10030);
    u_skc_host_model.set_pins(1'b0, 1'b0, 1'b0, 1'b0);
    wait_rise(7, 1, 8);
    key_run(8'h02, 3'b111, 3, 9990, 10030);
    wait_none(0, 100);
    u_skc_host_model.set_pins(1'b0, 1'b0, 1'b0, 1'b0);
    key_run(8'h08, 3'b011, 0, 10000, 10045);
    u_skc_host_model.set_pins(1'b0, 1'b0, 1'b0, 1'b0);
    key_run(8'h16, 3'b100, 1, 10000, 10045);
    @(negedge sys_clk);
    chk(8'(powerup_ok), 8'h00);
    u_skc_host_model.set_pins(1'b0, 1'b0, 1'b0, 1'b0);
    wait_rise(2, 200, 240);
    end_of_test();
  end
endmodule
